/* File: dv/dps_monitor.sv */
// Purpose: Assertions on the sequencer link and on the device outputs
// Assumes: Host end makes mclk; pwr_state and gain live on mclk
// Notes:   Audio checks sleep while reset or mclk loss is flagged
`timescale 1ns/100ps
`default_nettype none
module dps_monitor #(
   parameter int unsigned BCLK_TMO = 64,
   parameter int unsigned MCLK_TMO = 16
) (
   // Clock and reset
   input wire logic                       clk_sys,
   input wire logic                       sys_rst,
   // Link
   input wire logic                       mclk,
   input wire logic                       bclk,
   input wire logic                       mute_n,
   // Device outputs
   input wire logic                       mclk_ok,
   input wire logic                       cp_on,
   input wire logic                       path_on,
   input wire logic [dps_pkg::GAIN_W-1:0] gain,
   input wire logic [1:0]                 pwr_state
);
   // ****************************************************
   // Idle counters
   // ****************************************************
   // Saturating, so a long stop never wraps back to a legal count
   logic [7:0] bidle_r;
   logic [7:0] midle_r;
   logic       bclk_r;
   logic       mclk_r;
   logic       off_a;
   assign off_a = sys_rst | ~mclk_ok;
   always_ff @(posedge mclk) begin
      bclk_r  <= bclk;
      bidle_r <= (bclk != bclk_r) ? 8'h00 : ((&bidle_r) ? bidle_r : bidle_r + 8'h01);
   end
   always_ff @(posedge clk_sys) begin
      mclk_r  <= mclk;
      midle_r <= (mclk != mclk_r) ? 8'h00 : ((&midle_r) ? midle_r : midle_r + 8'h01);
   end
   // ****************************************************
   // Assertions
   // ****************************************************
   chk_enab_full:
      assert property (@(posedge mclk) disable iff (off_a)
         pwr_state == dps_pkg::DPS_ENAB |-> gain == dps_pkg::GAIN_FULL)
      else $error("enabled without full gain");
   chk_stby_muted:
      assert property (@(posedge mclk) disable iff (off_a)
         pwr_state == dps_pkg::DPS_STBY |-> gain == dps_pkg::GAIN_ZERO)
      else $error("standby with gain");
   chk_ramp_step:
      assert property (@(posedge mclk) disable iff (off_a)
         pwr_state == dps_pkg::DPS_MDN && $past(pwr_state) == dps_pkg::DPS_MDN
         |-> gain == $past(gain) || gain + 1 == $past(gain))
      else $error("ramp gain not stepping down");
   chk_enab_exit:
      assert property (@(posedge mclk) disable iff (off_a)
         $past(pwr_state) == dps_pkg::DPS_ENAB
         |-> pwr_state inside {dps_pkg::DPS_ENAB, dps_pkg::DPS_MDN, dps_pkg::DPS_OFF})
      else $error("enabled left without ramp");
   chk_off_exit:
      assert property (@(posedge mclk) disable iff (off_a)
         $past(pwr_state) == dps_pkg::DPS_OFF && pwr_state != dps_pkg::DPS_OFF
         |-> pwr_state == ($past(mute_n, 3) ? dps_pkg::DPS_ENAB : dps_pkg::DPS_STBY))
      else $error("wrong state after off");
   chk_bclk_lost:
      assert property (@(posedge mclk) disable iff (off_a)
         bidle_r > BCLK_TMO + 8 |-> pwr_state != dps_pkg::DPS_ENAB)
      else $error("enabled with bit clock stopped");
   chk_mclk_lost:
      assert property (@(posedge clk_sys) disable iff (sys_rst)
         midle_r > MCLK_TMO + 6 |-> !mclk_ok)
      else $error("master clock loss not flagged");
   chk_loss_off:
      assert property (@(posedge clk_sys) disable iff (sys_rst)
         !mclk_ok [*4] |-> !cp_on && !path_on)
      else $error("power kept without master clock");
   chk_pump_path:
      assert property (@(posedge clk_sys) disable iff (sys_rst)
         path_on |-> cp_on)
      else $error("path on without charge pump");
endmodule // dps_monitor
`default_nettype wire

/* File: dv/dps_tb_top.sv */
// Purpose: Host and device ends joined; user side driven and checked
// Assumes: Host divides clk_sys for mclk and bclk
// Notes:   Short ramp and waits through parameters to keep the run brief
`timescale 1ns/100ps
`default_nettype none
module dps_tb_top;
   logic                       clk_sys;
   logic                       sys_rst;
   logic                       mclk_run;
   logic                       bclk_run;
   logic                       play;
   logic                       rate_chg;
   logic                       busy;
   logic                       mclk_ok;
   logic                       cp_on;
   logic                       path_on;
   logic [dps_pkg::GAIN_W-1:0] gain;
   logic [1:0]                 pwr_state;
   logic [1:0]                 prev;
   logic [1:0]                 exp_q[$];
   logic [31:0]                lfsr;
   int                         num_errors;
   int                         check_count;
   dps_link_if link ();
   dps_host #(.STOP_WAIT(14000), .RATE_HOLD(100)) dps_host_i (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .mclk_run(mclk_run), .bclk_run(bclk_run), .play(play),
      .rate_chg(rate_chg), .busy(busy), .link(link));
   dps_dev #(.FS_DIV(4)) dps_dev_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .mclk_ok(mclk_ok), .cp_on(cp_on), .path_on(path_on), .gain(gain),
      .pwr_state(pwr_state), .link(link));
   dps_monitor #(.BCLK_TMO(dps_pkg::BCLK_TMO_MCLK), .MCLK_TMO(dps_pkg::MCLK_TMO_SYS))
   dps_monitor_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .mclk(link.mclk),
      .bclk(link.bclk), .mute_n(link.mute_n), .mclk_ok(mclk_ok), .cp_on(cp_on),
      .path_on(path_on), .gain(gain), .pwr_state(pwr_state));
   // ****************************************************
   // Tasks
   // ****************************************************
   task automatic check(input logic [9:0] seen, input logic [9:0] want);
      check_count++;
      if (seen !== want) begin
         num_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   task automatic print_verdict;
      $display("Checks %0d, errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic drive(input logic m, input logic b, input logic p);
      @(negedge clk_sys);
      mclk_run = m;
      bclk_run = b;
      play = p;
   endtask
   // Bounded wait until every noted state change has been seen
   task automatic wait_q(input int lim);
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < lim) begin
         @(negedge clk_sys);
         n++;
      end
      if (exp_q.size() != 0) begin
         num_errors++;
         $display("Error at %0t: state change missing", $time);
         exp_q.delete();
      end
      // Status outputs cross back through three flops; let them settle
      repeat (4) @(negedge clk_sys);
   endtask
   // ****************************************************
   // Clock, watchdog, state watcher
   // ****************************************************
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   initial begin
      #600000;
      num_errors++;
      $display("Error at %0t: watchdog expired", $time);
      print_verdict;
   end
   // Unknown states before mclk first runs are skipped, not matched
   always @(negedge clk_sys) begin
      if (^pwr_state !== 1'bx) begin
         if (pwr_state !== prev) begin
            check(pwr_state, exp_q.size() ? exp_q.pop_front() : prev);
         end
         prev = pwr_state;
      end
   end
   // ****************************************************
   // Main sequence
   // ****************************************************
   initial begin
      int n;
      sys_rst = 1'b1;
      mclk_run = 1'b0;
      bclk_run = 1'b0;
      play = 1'b0;
      rate_chg = 1'b0;
      prev = dps_pkg::DPS_OFF;
      lfsr = 32'h9439;
      num_errors = 0;
      check_count = 0;
      repeat (20) @(negedge clk_sys);
      sys_rst = 1'b0;
      drive(1'b1, 1'b1, 1'b0);
      exp_q.push_back(dps_pkg::DPS_STBY);
      wait_q(3000);
      check(cp_on, 1'b1);
      check(path_on, 1'b0);
      check(mclk_ok, 1'b1);
      // Bit clock stops; wait out its timeout before mute moves at random
      drive(1'b1, 1'b0, 1'b0);
      repeat (400) @(negedge clk_sys);
      repeat (40) begin
         lfsr = lfsr_next(lfsr);
         drive(1'b1, 1'b0, lfsr[0]);
         repeat (8) @(negedge clk_sys);
      end
      check(pwr_state, dps_pkg::DPS_STBY);
      drive(1'b1, 1'b1, 1'b1);
      exp_q.push_back(dps_pkg::DPS_ENAB);
      wait_q(3000);
      check(gain, dps_pkg::GAIN_FULL);
      check(path_on, 1'b1);
      // Leave enabled by bit clock stop, then by mute
      for (int i = 0; i < 2; i++) begin
         drive(1'b1, i[0], ~i[0]);
         exp_q.push_back(dps_pkg::DPS_MDN);
         exp_q.push_back(dps_pkg::DPS_STBY);
         wait_q(20000);
         check(cp_on, 1'b1);
         check(path_on, 1'b0);
         check(gain, dps_pkg::GAIN_ZERO);
         drive(1'b1, 1'b1, 1'b1);
         exp_q.push_back(dps_pkg::DPS_ENAB);
         wait_q(3000);
      end
      // Rate change: host holds mute low briefly; ramp still completes
      @(negedge clk_sys);
      rate_chg = 1'b1;
      @(negedge clk_sys);
      rate_chg = 1'b0;
      check(busy, 1'b1);
      exp_q.push_back(dps_pkg::DPS_MDN);
      exp_q.push_back(dps_pkg::DPS_STBY);
      exp_q.push_back(dps_pkg::DPS_ENAB);
      wait_q(20000);
      // Quiet stop: mute first, mclk kept through the ramp, then stopped
      drive(1'b0, 1'b1, 1'b1);
      exp_q.push_back(dps_pkg::DPS_MDN);
      exp_q.push_back(dps_pkg::DPS_STBY);
      wait_q(20000);
      check(busy, 1'b1);
      n = 0;
      while (busy !== 1'b0 && n < 3000) begin
         @(negedge clk_sys);
         n++;
      end
      check(busy, 1'b0);
      repeat (40) @(negedge clk_sys);
      check(mclk_ok, 1'b0);
      check(cp_on, 1'b0);
      // Restart with mute high goes straight to enabled
      drive(1'b1, 1'b1, 1'b1);
      exp_q.push_back(dps_pkg::DPS_OFF);
      exp_q.push_back(dps_pkg::DPS_ENAB);
      wait_q(3000);
      check(path_on, 1'b1);
      print_verdict;
   end
endmodule // dps_tb_top
`default_nettype wire

/* File: rtl/dps_dev.sv */
// Purpose: DAC end: power state machine and soft-mute gain
// Assumes: clk_sys runs free; master clock may stop at any time
// Notes:   Audio logic runs on the link master clock
`timescale 1ns/100ps
`default_nettype none
module dps_dev #(
   parameter int unsigned BCLK_TMO = dps_pkg::BCLK_TMO_MCLK,
   parameter int unsigned MCLK_TMO = dps_pkg::MCLK_TMO_SYS,
   parameter int unsigned FS_DIV   = dps_pkg::MCLK_PER_FS
) (
   // Free-running side
   input  wire logic                       clk_sys,
   input  wire logic                       sys_rst,
   output logic                            mclk_ok,
   output logic                            cp_on,
   output logic                            path_on,
   // Audio side, master clock domain
   output logic [dps_pkg::GAIN_W-1:0]      gain,
   output logic [1:0]                      pwr_state,
   // Link
   dps_link_if.dev                         link
);
   // ****************************************************
   // Master clock loss detector on clk_sys
   // ****************************************************
   // Pin sampled straight, so mclk must run below half the clk_sys rate
   logic       mt_s1_r, mt_s2_r, mt_s3_r;
   logic [7:0] mto_r, mto_nxt;
   logic       lost_r, lost_nxt;
   logic       rreq_r, rreq_nxt;

   always_comb begin
      mto_nxt  = mto_r;
      lost_nxt = lost_r;
      if (mt_s2_r != mt_s3_r) begin
         mto_nxt  = 8'h00;
         lost_nxt = 1'b0;
      end else if (mto_r == 8'(MCLK_TMO - 1)) begin
         lost_nxt = 1'b1;                  // [R14]
      end else begin
         mto_nxt = mto_r + 8'h01;          // [R14]
      end
      // Loss holds the audio domain in reset, so it lands in off [R8]
      rreq_nxt = sys_rst || lost_nxt;
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         mt_s1_r <= 1'b0;
         mt_s2_r <= 1'b0;
         mt_s3_r <= 1'b0;
         mto_r   <= 8'h00;
         lost_r  <= 1'b1;
         rreq_r  <= 1'b1;
      end else begin
         mt_s1_r <= link.mclk;
         mt_s2_r <= mt_s1_r;
         mt_s3_r <= mt_s2_r;
         mto_r   <= mto_nxt;
         lost_r  <= lost_nxt;
         rreq_r  <= rreq_nxt;
      end
   end

   // ****************************************************
   // Reset and pin synchronisers on the master clock
   // ****************************************************
   logic rst_s1_r, rst_m_r;
   logic bc_s1_r, bc_s2_r, bc_s3_r;
   logic mu_s1_r, mute_s_r;

   // A stopped master clock freezes these; the sys side covers that case
   always_ff @(posedge link.mclk) begin
      rst_s1_r <= rreq_r;
      rst_m_r  <= rst_s1_r;
      bc_s1_r  <= link.bclk;
      bc_s2_r  <= bc_s1_r;
      bc_s3_r  <= bc_s2_r;
      mu_s1_r  <= link.mute_n;
      mute_s_r <= mu_s1_r;
   end

   // ****************************************************
   // Bit clock activity monitor
   // ****************************************************
   logic [7:0] bto_r, bto_nxt;
   logic       bact_r, bact_nxt;

   always_comb begin
      bto_nxt  = bto_r;
      bact_nxt = bact_r;
      if (bc_s2_r != bc_s3_r) begin
         bto_nxt  = 8'h00;                 // [R13]
         bact_nxt = 1'b1;
      end else if (bto_r == 8'(BCLK_TMO - 1)) begin
         bact_nxt = 1'b0;                  // [R12] [R13]
      end else begin
         bto_nxt = bto_r + 8'h01;          // [R13]
      end
   end

   always_ff @(posedge link.mclk) begin
      if (rst_m_r) begin
         bto_r  <= 8'h00;
         bact_r <= 1'b0;
      end else begin
         bto_r  <= bto_nxt;
         bact_r <= bact_nxt;
      end
   end

   // ****************************************************
   // Power state machine and soft mute
   // ****************************************************
   dps_pkg::dps_state_t             st_r, st_nxt;
   logic [dps_pkg::GAIN_W-1:0]      gain_r, gain_nxt;
   logic [9:0]                      fsc_r, fsc_nxt;
   logic                            tick;
   logic                            cp_m_r, cp_m_nxt, path_m_r, path_m_nxt;

   always_comb begin
      st_nxt   = st_r;
      gain_nxt = gain_r;
      tick     = (fsc_r == 10'(FS_DIV - 1));
      fsc_nxt  = tick ? 10'h000 : fsc_r + 10'h001;
      unique case (st_r)
         dps_pkg::DPS_OFF: begin
            if (bact_r) begin
               if (mute_s_r) begin
                  st_nxt   = dps_pkg::DPS_ENAB;   // [R10]
                  gain_nxt = dps_pkg::GAIN_FULL;  // [R11]
               end else begin
                  st_nxt = dps_pkg::DPS_STBY;     // [R1]
               end
            end
         end
         dps_pkg::DPS_STBY: begin
            // Bit clock loss alone does not leave standby [R2]
            if (mute_s_r && bact_r) begin
               st_nxt   = dps_pkg::DPS_ENAB;      // [R3]
               gain_nxt = dps_pkg::GAIN_FULL;     // [R11]
            end
         end
         dps_pkg::DPS_ENAB: begin
            if (!mute_s_r || !bact_r) begin
               st_nxt = dps_pkg::DPS_MDN;         // [R4] [R6] [R12]
            end
         end
         dps_pkg::DPS_MDN: begin
            // Ramp runs to the end even if mute is released, for a quiet stop
            if (gain_r == dps_pkg::GAIN_ZERO) begin
               st_nxt = dps_pkg::DPS_STBY;        // [R6]
            end else if (tick) begin
               gain_nxt = gain_r - 10'h001;       // [R11]
            end
         end
      endcase
      cp_m_nxt   = (st_nxt != dps_pkg::DPS_OFF);  // [R4]
      path_m_nxt = (st_nxt == dps_pkg::DPS_ENAB) || (st_nxt == dps_pkg::DPS_MDN);
   end

   always_ff @(posedge link.mclk) begin
      if (rst_m_r) begin
         st_r     <= dps_pkg::DPS_OFF;            // [R8]
         gain_r   <= dps_pkg::GAIN_ZERO;
         fsc_r    <= 10'h000;
         cp_m_r   <= 1'b0;
         path_m_r <= 1'b0;
      end else begin
         st_r     <= st_nxt;
         gain_r   <= gain_nxt;
         fsc_r    <= fsc_nxt;
         cp_m_r   <= cp_m_nxt;
         path_m_r <= path_m_nxt;
      end
   end

   // ****************************************************
   // Status back on clk_sys
   // ****************************************************
   logic cp_s1_r, cp_s2_r, pa_s1_r, pa_s2_r;
   logic ok_r, cp_r, path_r;
   logic ok_nxt, cp_nxt, path_nxt;

   always_comb begin
      // Loss wins at once, the frozen audio side cannot be trusted [R8]
      ok_nxt   = !lost_r;
      cp_nxt   = !lost_r && cp_s2_r;
      path_nxt = !lost_r && pa_s2_r;
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cp_s1_r <= 1'b0;
         cp_s2_r <= 1'b0;
         pa_s1_r <= 1'b0;
         pa_s2_r <= 1'b0;
         ok_r    <= 1'b0;
         cp_r    <= 1'b0;
         path_r  <= 1'b0;
      end else begin
         cp_s1_r <= cp_m_r;
         cp_s2_r <= cp_s1_r;
         pa_s1_r <= path_m_r;
         pa_s2_r <= pa_s1_r;
         ok_r    <= ok_nxt;
         cp_r    <= cp_nxt;
         path_r  <= path_nxt;
      end
   end

   assign mclk_ok   = ok_r;
   assign cp_on     = cp_r;
   assign path_on   = path_r;
   assign gain      = gain_r;
   assign pwr_state = st_r;

endmodule // dps_dev
`default_nettype wire

/* File: rtl/dps_host.sv */
// Purpose: Host audio source end: makes clocks, drives mute pin
// Assumes: User controls come from clk_sys logic
// Notes:   Master clock is divided from clk_sys and driven out
`timescale 1ns/100ps
`default_nettype none
module dps_host #(
   parameter int unsigned STOP_WAIT = dps_pkg::STOP_WAIT_SYS,
   parameter int unsigned RATE_HOLD = dps_pkg::RATE_HOLD_SYS
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   // User side
   input  wire logic mclk_run,
   input  wire logic bclk_run,
   input  wire logic play,
   input  wire logic rate_chg,
   output logic      busy,
   // Link
   dps_link_if.host  link
);
   // ****************************************************
   // Sequencer
   // ****************************************************
   dps_pkg::dps_hstate_t           st_r, st_nxt;
   logic [dps_pkg::CNT_W-1:0]      cnt_r, cnt_nxt;

   always_comb begin
      st_nxt  = st_r;
      cnt_nxt = cnt_r;
      unique case (st_r)
         dps_pkg::DPS_H_IDLE: begin
            if (mclk_run) st_nxt = dps_pkg::DPS_H_RUN;
         end
         dps_pkg::DPS_H_RUN: begin
            if (!mclk_run) begin
               // Mute first so the shutdown is quiet [R9]
               st_nxt  = dps_pkg::DPS_H_QUIET;
               cnt_nxt = dps_pkg::CNT_W'(STOP_WAIT);
            end else if (rate_chg) begin
               st_nxt  = dps_pkg::DPS_H_HOLD; // [R7]
               cnt_nxt = dps_pkg::CNT_W'(RATE_HOLD);
            end
         end
         dps_pkg::DPS_H_QUIET: begin
            // Clock keeps running through the ramp [R5]
            if (cnt_r == '0) st_nxt = dps_pkg::DPS_H_IDLE;
            else cnt_nxt = cnt_r - 1'b1;
         end
         dps_pkg::DPS_H_HOLD: begin
            if (cnt_r == '0) st_nxt = dps_pkg::DPS_H_RUN;
            else cnt_nxt = cnt_r - 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st_r  <= dps_pkg::DPS_H_IDLE;
         cnt_r <= '0;
      end else begin
         st_r  <= st_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // ****************************************************
   // Clock dividers and pins
   // ****************************************************
   logic [7:0] mdiv_r, mdiv_nxt, bdiv_r, bdiv_nxt;
   logic       mclk_r, mclk_nxt, bclk_r, bclk_nxt, mute_r, mute_nxt;
   logic       busy_r, busy_nxt;

   always_comb begin
      mdiv_nxt = mdiv_r + 8'h01;
      mclk_nxt = mclk_r;
      bdiv_nxt = bdiv_r + 8'h01;
      bclk_nxt = bclk_r;
      if (mdiv_r == 8'(dps_pkg::MCLK_HALF_SYS - 1)) begin
         mdiv_nxt = 8'h00;
         mclk_nxt = (st_r != dps_pkg::DPS_H_IDLE) && !mclk_r;
      end
      if (bdiv_r == 8'(dps_pkg::BCLK_HALF_SYS - 1)) begin
         bdiv_nxt = 8'h00;
         bclk_nxt = (st_r != dps_pkg::DPS_H_IDLE) && bclk_run && !bclk_r;
      end
      // Mute high only in plain running [R1] [R3] [R10]
      mute_nxt = (st_r == dps_pkg::DPS_H_RUN) && play;
      busy_nxt = (st_nxt == dps_pkg::DPS_H_QUIET) || (st_nxt == dps_pkg::DPS_H_HOLD);
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         mdiv_r <= 8'h00;
         bdiv_r <= 8'h00;
         mclk_r <= 1'b0;
         bclk_r <= 1'b0;
         mute_r <= 1'b0;
         busy_r <= 1'b0;
      end else begin
         mdiv_r <= mdiv_nxt;
         bdiv_r <= bdiv_nxt;
         mclk_r <= mclk_nxt;
         bclk_r <= bclk_nxt;
         mute_r <= mute_nxt;
         busy_r <= busy_nxt;
      end
   end

   assign link.mclk   = mclk_r;
   assign link.bclk   = bclk_r;
   assign link.mute_n = mute_r;
   assign busy        = busy_r;

endmodule // dps_host
`default_nettype wire

/* File: rtl/dps_link_if.sv */
// Purpose: Pins between host audio source and DAC sequencer
// Assumes: Host drives every pin; all are one-way
// Notes:   Master clock runs the device end's audio logic; clk_sys runs its loss detector
`timescale 1ns/100ps
`default_nettype none
interface dps_link_if;
   logic mclk;
   logic bclk;
   logic mute_n;

   modport dev  (input mclk, input bclk, input mute_n);
   modport host (output mclk, output bclk, output mute_n);
endinterface
`default_nettype wire

/* File: rtl/dps_pkg.sv */
// Purpose: Shared constants and types for the DAC clock/mute power sequencer
// Assumes: Device end audio logic runs on the link master clock, host end on clk_sys
// Notes:   Notes on behaviour list below
//
// Notes on behaviour
// R1: Off to standby: clocks start, mute low
// R2: Standby holds if bit clock stops
// R3: Standby to enabled: mute high, bit clock running
// R4: Enabled to standby on mute low or clock stop
// R5: Host keeps master clock during enabled-to-standby
// R6: Leaving enabled always soft-mutes then powers down; on master clock loss the code drops from enabled straight to off
// R7: Host standbys before rapid rate changes
// R8: Master clock stop forces off anywhere
// R9: Host standbys before stopping master clock
// R10: Off to enabled: clocks start, mute high
// R11: Mute ramps over 800 samples, release steps
// R12: Bit clock loss mutes output automatically
// R13: Bit clock timeout counted in master clocks
// R14: Free-running detector catches master clock loss
package dps_pkg;

   // ****************************************************
   // States
   // ****************************************************
   typedef enum logic [1:0] {
      DPS_OFF  = 2'h0,
      DPS_STBY = 2'h1,
      DPS_ENAB = 2'h3,
      DPS_MDN  = 2'h2
   } dps_state_t;

   typedef enum logic [1:0] {
      DPS_H_IDLE  = 2'h0,
      DPS_H_RUN   = 2'h1,
      DPS_H_QUIET = 2'h3,
      DPS_H_HOLD  = 2'h2
   } dps_hstate_t;

   // ****************************************************
   // Timing and levels
   // ****************************************************
   localparam int unsigned SYS_PERIOD_NS   = 8;
   localparam int unsigned RAMP_SAMPLES    = 800;
   localparam int unsigned GAIN_W          = 10;
   localparam logic [9:0]  GAIN_FULL       = 10'h320;
   localparam logic [9:0]  GAIN_ZERO       = 10'h000;
   localparam int unsigned MCLK_PER_FS     = 256;
   localparam int unsigned BCLK_TMO_MCLK   = 64;
   localparam int unsigned MCLK_TMO_SYS    = 16;
   localparam int unsigned MCLK_HALF_SYS   = 2;
   localparam int unsigned BCLK_HALF_SYS   = 8;
   localparam int unsigned RATE_HOLD_FS    = 1026;
   localparam int unsigned RATE_HOLD_SYS   =
      RATE_HOLD_FS * MCLK_PER_FS * 2 * MCLK_HALF_SYS;
   localparam int unsigned STOP_WAIT_SYS   =
      (RAMP_SAMPLES + 2) * MCLK_PER_FS * 2 * MCLK_HALF_SYS;
   localparam int unsigned CNT_W           = 32;

endpackage
